/* File: shared/pcd_map.svh */
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// ****************************************
// Timing configuration field, bits 26:20 seen as [6:0]
// ****************************************
`define PCD_CFG_W 7
`define PCD_CFG_SIZE_MSB 2
`define PCD_CFG_SIZE_LSB 0
`define PCD_CFG_LOW_MSB 6
`define PCD_CFG_LOW_LSB 3
`define PCD_CFG_RESET 7'h00

// ****************************************
// Window geometry
// ****************************************
`define PCD_IO_MAX_LOG2 4'h8
`define PCD_IO_MIN_LOG2 4'h2
`define PCD_LOW_BIT_MAX 4'h8
`define PCD_MEM_SEL_MSB 11
`define PCD_MEM_SEL_LSB 10
`define PCD_MEM_ADDR_MSB 9
`define PCD_MEM_ADDR_LSB 2
`define PCD_MEM_LCFG_BIT 7
`define PCD_PP_EXT_LOG2 4'h3

// ****************************************
// Base address register numbers
// ****************************************
`define PCD_BAR_LB_IO 3'h0
`define PCD_BAR_LB_MEM 3'h1
`define PCD_BAR_PP_BASE 3'h0
`define PCD_BAR_PP_EXT 3'h1
`define PCD_BAR_F0_LCFG_IO 3'h4
`define PCD_BAR_F0_LCFG_MEM 3'h5
`define PCD_BAR_F1_LCFG_IO 3'h2
`define PCD_BAR_F1_LCFG_MEM 3'h3

// ****************************************
// Reset values of outputs
// ****************************************
`define PCD_ADDR_RESET 8'h00
`define PCD_SEL_IDLE_N 4'hF

`endif

/* File: shared/pcd_pkg.sv */
package pcd_pkg;
	typedef logic [7:0] pcd_laddr_t;
	typedef logic [11:0] pcd_paddr_t;
	typedef logic [3:0] pcd_sel_n_t;
	typedef enum logic [1:0] {
		PCD_TGT_NONE = 2'b00,
		PCD_TGT_LBUS = 2'b01,
		PCD_TGT_PPORT = 2'b10,
		PCD_TGT_LCFG = 2'b11
	} pcd_target_t;
endpackage

/* File: shared/pcd_if.sv */
`timescale 1ns/1ps
interface pcd_if;
	logic is_mem;
	logic [11:0] addr;
	logic [2:0] size_code;
	logic [3:0] low_bit;
	logic [7:0] local_addr;
	logic [1:0] sel;
	logic [3:0] win_log2;
	modport src (
		output is_mem, addr, size_code, low_bit,
		input local_addr, sel, win_log2
	);
	modport dec (
		input is_mem, addr, size_code, low_bit,
		output local_addr, sel, win_log2
	);
endinterface

/* File: logic/pcd_decode.sv */
`timescale 1ns/1ps
`include "pcd_map.svh"
module pcd_decode (
	pcd_if.dec d // Access in, decode out
);
	import pcd_pkg::*;

	wire [3:0] win_log2;
	wire [8:0] win_mask;
	wire [7:0] io_addr;
	wire [3:0] low_clamped;
	wire [9:0] io_shifted;
	wire [1:0] io_sel;

	// Code 000 has no printed meaning; it keeps the full window
	assign win_log2 = (d.size_code == 3'h0) ? `PCD_IO_MAX_LOG2 :
		4'(d.size_code) + 4'h1;
	assign win_mask = (9'h001 << win_log2) - 9'h001;
	assign io_addr = d.addr[7:0] & win_mask[7:0]; // see RQ3 see RQ4
	assign low_clamped = (d.low_bit > `PCD_LOW_BIT_MAX) ?
		`PCD_LOW_BIT_MAX : d.low_bit; // see RQ7
	// Zeroed upper lines make RQ6/RQ7 fall out of the same shift
	assign io_shifted = {2'b00, io_addr} >> low_clamped;
	assign io_sel = io_shifted[1:0]; // see RQ5 see RQ6 see RQ7

	assign d.win_log2 = win_log2;
	assign d.local_addr = d.is_mem ?
		d.addr[`PCD_MEM_ADDR_MSB:`PCD_MEM_ADDR_LSB] : io_addr; // see RQ9
	assign d.sel = d.is_mem ?
		d.addr[`PCD_MEM_SEL_MSB:`PCD_MEM_SEL_LSB] : io_sel; // see RQ8
endmodule

/* File: logic/pcd_top.sv */
`timescale 1ns/1ps
`include "pcd_map.svh"
// Operation
// RQ1 - Mode low bridges bus; high gives parallel port
// RQ2 - Window size and decode bit from field
// RQ3 - Full window passes address bits 7:0
// RQ4 - Smaller window zeroes upper local address
// RQ5 - Two bits from low bit pick select
// RQ6 - Top in-range bit uses selects 0, 1
// RQ7 - Bit beyond window: only select 0
// RQ8 - Memory selects from address bits 11:10
// RQ9 - Memory drives address bits 9:2 out
// RQ10 - Each select covers a 1K memory region
// RQ11 - Strobe style: selects become data strobes
// RQ12 - Parallel port: second block fixed 8 bytes
// RQ13 - First block size from field, 001=4
// RQ14 - Host places extended block 0x400 above
// RQ15 - Local registers reachable from both functions
// RQ16 - I/O byte only; memory word or dword (code also accepts a memory byte)
// RQ17 - Select low only during decoded access
module pcd_top (
	input wire logic clk, // 250 MHz clock
	input wire logic arst_n, // Async reset, active low
	input wire logic mode_pin, // Mode strap pin, async
	input wire logic strobe_style, // Strobe-style bus selected
	input wire logic [`PCD_CFG_W-1:0] timing_field, // Field 26:20
	input wire logic acc_valid, // Access in progress
	input wire logic acc_func, // Target function number
	input wire logic [2:0] acc_bar, // Hit base address register
	input wire logic acc_is_mem, // Memory, not I/O
	input wire pcd_pkg::pcd_paddr_t acc_addr, // Offset in block
	input wire logic [3:0] acc_byte_en, // Byte enables, high
	output pcd_pkg::pcd_laddr_t local_addr_out, // Local address
	output logic periph_select0_n, // Chip select 0
	output logic periph_select1_n, // Chip select 1
	output logic periph_select2_n, // Chip select 2
	output logic periph_select3_n, // Chip select 3
	output logic periph_strobe0_n, // Data strobe 0
	output logic periph_strobe1_n, // Data strobe 1
	output logic periph_strobe2_n, // Data strobe 2
	output logic periph_strobe3_n, // Data strobe 3
	output logic pport_mode, // Synchronised mode level
	output pcd_pkg::pcd_target_t acc_target, // Decoded target
	output logic lcfg_refused, // Bad local reg width
	output logic [3:0] pp_base_log2, // First block size log2
	output logic [3:0] pp_ext_log2, // Second block size log2
	output logic [3:0] lb_io_log2 // Bus I/O window log2
);
	import pcd_pkg::*;

	// ****************************************
	// Mode pin synchroniser
	// ****************************************
	logic mode_meta;
	logic mode_sync;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			mode_meta <= mode_pin;
			mode_sync <= mode_meta;
		end
	end

	// ****************************************
	// Address decoder
	// ****************************************
	pcd_if dq ();

	assign dq.is_mem = acc_is_mem;
	assign dq.addr = acc_addr;
	assign dq.size_code =
		timing_field[`PCD_CFG_SIZE_MSB:`PCD_CFG_SIZE_LSB]; // see RQ2
	assign dq.low_bit =
		timing_field[`PCD_CFG_LOW_MSB:`PCD_CFG_LOW_LSB]; // see RQ2

	pcd_decode u_decode (
		.d(dq.dec)
	);

	// ****************************************
	// Target decode
	// ****************************************
	wire f0 = (acc_func == 1'b0);
	wire f1 = (acc_func == 1'b1);
	wire bus_mode = !mode_sync; // see RQ1

	// BAR5 of function 0 shares its window with the UARTs
	wire lcfg_f0_io = f0 && !acc_is_mem &&
		(acc_bar == `PCD_BAR_F0_LCFG_IO);
	wire lcfg_f0_mem = f0 && acc_is_mem &&
		(acc_bar == `PCD_BAR_F0_LCFG_MEM) &&
		acc_addr[`PCD_MEM_LCFG_BIT];
	wire lcfg_f1_io = f1 && !acc_is_mem &&
		(acc_bar == `PCD_BAR_F1_LCFG_IO);
	wire lcfg_f1_mem = f1 && acc_is_mem &&
		(acc_bar == `PCD_BAR_F1_LCFG_MEM);
	wire lcfg_hit = lcfg_f0_io || lcfg_f0_mem ||
		lcfg_f1_io || lcfg_f1_mem; // see RQ15

	// Count of enabled lanes
	wire [2:0] lanes = 3'(acc_byte_en[0]) + 3'(acc_byte_en[1]) +
		3'(acc_byte_en[2]) + 3'(acc_byte_en[3]);
	wire width_ok = acc_is_mem ?
		(lanes == 3'h2 || lanes == 3'h4 || lanes == 3'h1) :
		(lanes == 3'h1); // see RQ16

	wire lb_io_hit = f1 && bus_mode && !acc_is_mem &&
		(acc_bar == `PCD_BAR_LB_IO); // see RQ1
	wire lb_mem_hit = f1 && bus_mode && acc_is_mem &&
		(acc_bar == `PCD_BAR_LB_MEM); // see RQ1 see RQ10
	wire lb_hit = lb_io_hit || lb_mem_hit;

	wire pp_hit = f1 && mode_sync && !acc_is_mem &&
		(acc_bar == `PCD_BAR_PP_BASE ||
		acc_bar == `PCD_BAR_PP_EXT); // see RQ12

	// Accesses outside the sized I/O window never reach the bus
	wire [8:0] io_limit = 9'h001 << dq.win_log2;
	wire io_in_range = ({1'b0, acc_addr[7:0]} < io_limit) &&
		(acc_addr[11:8] == 4'h0);
	wire lb_go = acc_valid && lb_hit &&
		(lb_mem_hit || io_in_range); // see RQ17

	wire [3:0] sel_onehot_n = ~(4'h1 << dq.sel);
	wire [3:0] next_sel_n = lb_go ? sel_onehot_n :
		`PCD_SEL_IDLE_N; // see RQ17
	wire [3:0] next_cs_n = strobe_style ?
		`PCD_SEL_IDLE_N : next_sel_n;
	wire [3:0] next_ds_n = strobe_style ?
		next_sel_n : `PCD_SEL_IDLE_N; // see RQ11

	wire [7:0] next_laddr = lb_go ? dq.local_addr :
		`PCD_ADDR_RESET;

	pcd_target_t next_target;
	always_comb begin
		next_target = PCD_TGT_NONE;
		if (acc_valid) begin
			if (lcfg_hit)
				next_target = PCD_TGT_LCFG;
			else if (lb_go)
				next_target = PCD_TGT_LBUS;
			else if (pp_hit)
				next_target = PCD_TGT_PPORT;
		end
	end

	wire next_refused = acc_valid && lcfg_hit && !width_ok;

	// ****************************************
	// Block sizes
	// ****************************************
	// Parallel-port base block follows the same size code
	wire [3:0] next_pp_base = dq.win_log2; // see RQ13
	wire [3:0] next_pp_ext = `PCD_PP_EXT_LOG2; // see RQ12

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			local_addr_out <= `PCD_ADDR_RESET;
			{periph_select3_n, periph_select2_n,
				periph_select1_n, periph_select0_n} <=
				`PCD_SEL_IDLE_N;
			{periph_strobe3_n, periph_strobe2_n,
				periph_strobe1_n, periph_strobe0_n} <=
				`PCD_SEL_IDLE_N;
		end else begin
			local_addr_out <= next_laddr; // see RQ3 see RQ9
			{periph_select3_n, periph_select2_n,
				periph_select1_n, periph_select0_n} <=
				next_cs_n; // see RQ5 see RQ8
			{periph_strobe3_n, periph_strobe2_n,
				periph_strobe1_n, periph_strobe0_n} <=
				next_ds_n; // see RQ11
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pport_mode <= 1'b0;
			acc_target <= PCD_TGT_NONE;
			lcfg_refused <= 1'b0;
		end else begin
			pport_mode <= mode_sync;
			acc_target <= next_target;
			lcfg_refused <= next_refused; // see RQ16
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pp_base_log2 <= `PCD_IO_MAX_LOG2;
			pp_ext_log2 <= `PCD_PP_EXT_LOG2;
			lb_io_log2 <= `PCD_IO_MAX_LOG2;
		end else begin
			pp_base_log2 <= mode_sync ? next_pp_base :
				`PCD_IO_MAX_LOG2;
			pp_ext_log2 <= next_pp_ext;
			lb_io_log2 <= dq.win_log2; // see RQ1
		end
	end
endmodule

/* File: dv/pcd_sva.sv */
`timescale 1ns/1ps
module pcd_sva
import pcd_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic strobe_style, // Style
	input wire logic [6:0] timing_field, // Field
	input wire logic acc_valid, // Valid
	input wire logic acc_func, // Function
	input wire logic [2:0] acc_bar, // BAR hit
	input wire logic acc_is_mem, // Memory
	input wire pcd_paddr_t acc_addr, // Offset
	input wire logic [3:0] acc_byte_en, // Lanes
	input wire pcd_laddr_t local_addr_out, // Address
	input wire logic periph_select0_n, // Select 0
	input wire logic periph_select1_n, // Select 1
	input wire logic periph_select2_n, // Select 2
	input wire logic periph_select3_n, // Select 3
	input wire logic periph_strobe0_n, // Strobe 0
	input wire logic periph_strobe1_n, // Strobe 1
	input wire logic periph_strobe2_n, // Strobe 2
	input wire logic periph_strobe3_n, // Strobe 3
	input wire logic pport_mode, // Mode
	input wire pcd_target_t acc_target, // Target
	input wire logic lcfg_refused, // Refused
	input wire logic [3:0] pp_ext_log2 // Ext size
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire [3:0] cs = {periph_select3_n, periph_select2_n,
		periph_select1_n, periph_select0_n};
	wire [3:0] ds = {periph_strobe3_n, periph_strobe2_n,
		periph_strobe1_n, periph_strobe0_n};
	// Design decodes with the level pport_mode shows one edge later
	wire lb = acc_valid && acc_func;
	wire lio = lb && acc_bar == 3'h0 && !acc_is_mem;
	wire lmem = lb && acc_bar == 3'h1 && acc_is_mem;
	wire lcf = acc_valid && !acc_is_mem &&
		(acc_func ? acc_bar == 3'h2 : acc_bar == 3'h4);
	function automatic logic [11:0] win(logic [6:0] f);
		return f[2:0] == 3'h0 ? 12'h100 : 12'h1 << ({1'b0, f[2:0]} + 4'h1);
	endfunction
	// Out-of-window offsets must leave every select idle
	function automatic logic [3:0] io_sel(logic [6:0] f, logic [11:0] a);
		logic [3:0] lo;
		lo = f[6:3] > 4'h8 ? 4'h8 : f[6:3];
		return a >= win(f) ? 4'hF : ~(4'h1 << ((a >> lo) & 12'h3));
	endfunction
	wire lin = lio && acc_addr < win(timing_field);
	property p_idle;
		!$past(acc_valid) |-> cs == 4'hF && ds == 4'hF;
	endproperty
	a_idle: assert property (p_idle) else $error("select idle");
	property p_mem_a;
		$past(lmem) && !pport_mode |->
			local_addr_out == $past(acc_addr[9:2]);
	endproperty
	a_mem_a: assert property (p_mem_a) else $error("mem addr");
	property p_mem_cs;
		$past(lmem && !strobe_style) && !pport_mode |->
			cs == 4'(~(4'h1 << $past(acc_addr[11:10])));
	endproperty
	a_mem_cs: assert property (p_mem_cs) else $error("mem cs");
	property p_strobe;
		$past(lmem && strobe_style) && !pport_mode |-> cs == 4'hF &&
			ds == 4'(~(4'h1 << $past(acc_addr[11:10])));
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe");
	property p_io_cs;
		$past(lio && !strobe_style) && !pport_mode |->
			cs == io_sel($past(timing_field), $past(acc_addr));
	endproperty
	a_io_cs: assert property (p_io_cs) else $error("io cs");
	property p_io_a;
		$past(lin) && !pport_mode |->
			local_addr_out == $past(acc_addr[7:0]);
	endproperty
	a_io_a: assert property (p_io_a) else $error("io addr");
	property p_lcfg;
		$past(lcf) |-> acc_target == PCD_TGT_LCFG &&
			lcfg_refused == ($countones($past(acc_byte_en)) != 1);
	endproperty
	a_lcfg: assert property (p_lcfg) else $error("lcfg");
	property p_ext;
		pp_ext_log2 == 4'h3;
	endproperty
	a_ext: assert property (p_ext) else $error("ext size");
	c_mem: cover property (lmem && strobe_style);
	c_io: cover property (lin);
	c_ref: cover property (lcfg_refused);
endmodule

/* File: dv/pcd_periph.sv */
`timescale 1ns/1ps
// Peripheral chip 3 latches the address it was selected with
module pcd_periph
import pcd_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic [3:0] cs_n, // Selects
	input wire pcd_laddr_t addr, // Address
	output pcd_laddr_t last3 // Latched address
);
	always_ff @(posedge clk) begin
		if (!cs_n[3]) begin
			last3 <= addr;
		end
	end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pcd_pkg::*;
	logic clk = 0, arst_n = 0, mode_pin = 0, strobe_style = 0;
	logic acc_valid = 0, acc_func = 0, acc_is_mem = 0, lcfg_refused;
	logic pport_mode;
	logic [6:0] timing_field = 7'h1C;
	logic [2:0] acc_bar = 3'h0;
	logic [11:0] acc_addr = 12'h000;
	logic [3:0] acc_byte_en = 4'h1;
	wire [3:0] cs, ds, pbl, pel, lbl;
	pcd_laddr_t local_addr_out, last3;
	pcd_target_t acc_target;
	int n_errors = 0, n_compared = 0;
	always #2 clk = ~clk;
	pcd_top dut (.clk(clk), .arst_n(arst_n), .mode_pin(mode_pin),
		.strobe_style(strobe_style), .timing_field(timing_field),
		.acc_valid(acc_valid), .acc_func(acc_func), .acc_bar(acc_bar),
		.acc_is_mem(acc_is_mem), .acc_addr(acc_addr),
		.acc_byte_en(acc_byte_en), .local_addr_out(local_addr_out),
		.periph_select0_n(cs[0]), .periph_select1_n(cs[1]),
		.periph_select2_n(cs[2]), .periph_select3_n(cs[3]),
		.periph_strobe0_n(ds[0]), .periph_strobe1_n(ds[1]),
		.periph_strobe2_n(ds[2]), .periph_strobe3_n(ds[3]),
		.pport_mode(pport_mode), .acc_target(acc_target),
		.lcfg_refused(lcfg_refused), .pp_base_log2(pbl),
		.pp_ext_log2(pel), .lb_io_log2(lbl));
	pcd_periph u_per (.clk(clk), .cs_n(cs), .addr(local_addr_out),
		.last3(last3));
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Inputs change at the falling edge; answer seen one edge later
	task acc(input logic f, input logic [2:0] b, input logic m,
		input logic [11:0] a, input logic [3:0] be);
		acc_valid = 1;
		acc_func = f;
		acc_bar = b;
		acc_is_mem = m;
		acc_addr = a;
		acc_byte_en = be;
		@(negedge clk);
	endtask
	initial begin
		repeat (4) @(negedge clk);
		chk({cs, ds}, 8'hFF);
		chk({pbl, pel}, 8'h83);
		chk({lbl, 2'h0, acc_target}, 8'h80);
		arst_n = 1;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 4; i++) begin
			acc(1, 0, 0, 12'h8 * i + 12'h7, 4'h1);
			chk(cs, 4'(~(4'h1 << i)));
			chk(local_addr_out, 8'h8 * i + 8'h7);
		end
		chk(lbl, 4'h5);
		timing_field = 7'h24;
		acc(1, 0, 0, 12'h010, 4'h1);
		chk(cs, 4'hD);
		timing_field = 7'h2C;
		acc(1, 0, 0, 12'h01F, 4'h1);
		chk(cs, 4'hE);
		acc(1, 0, 0, 12'h020, 4'h1);
		chk({cs, 2'h0, acc_target}, 8'hF0);
		timing_field = 7'h07;
		acc(1, 0, 0, 12'h0A5, 4'h1);
		chk(local_addr_out, 8'hA5);
		timing_field = 7'h1C;
		for (int i = 0; i < 4; i++) begin
			acc(1, 1, 1, 12'h400 * i + 12'h3FC, 4'h1);
			chk(cs, 4'(~(4'h1 << i)));
			chk(local_addr_out, 8'hFF);
			chk(acc_target, PCD_TGT_LBUS);
		end
		strobe_style = 1;
		acc(1, 1, 1, 12'h800, 4'h1);
		chk({cs, ds}, 8'hFB);
		// Peripheral latches one edge after its select falls
		chk(last3, 8'hFF);
		strobe_style = 0;
		acc_valid = 0;
		@(negedge clk);
		chk({cs, ds}, 8'hFF);
		acc(0, 4, 0, 12'h001, 4'h1);
		chk({lcfg_refused, acc_target}, 8'h03);
		acc(0, 4, 0, 12'h001, 4'h3);
		chk(lcfg_refused, 1);
		acc(0, 4, 0, 12'h002, 4'h4);
		chk({lcfg_refused, acc_target}, 8'h03);
		acc(1, 3, 1, 12'h004, 4'hF);
		chk({lcfg_refused, acc_target}, 8'h03);
		acc(0, 5, 1, 12'h080, 4'h3);
		chk(acc_target, PCD_TGT_LCFG);
		acc_valid = 0;
		mode_pin = 1;
		timing_field = 7'h01;
		repeat (3) @(negedge clk);
		chk({pport_mode, pbl}, 8'h12);
		chk(pel, 4'h3);
		acc(1, 0, 0, 12'h003, 4'h1);
		chk({cs, 2'h0, acc_target}, 8'hF2);
		// Host keeps this block 0x400 above the base one
		acc(1, 1, 0, 12'h007, 4'h1);
		chk(acc_target, PCD_TGT_PPORT);
		acc(1, 1, 1, 12'h000, 4'h1);
		chk({cs, 2'h0, acc_target}, 8'hF0);
		results();
	end
	initial begin
		#4000;
		n_errors++;
		results();
	end
endmodule
bind pcd_top pcd_sva u_sva (.*);
